// File: dv/mod_source.sv
// modulator stand-in: one multibit sample per master clock
// assumes the same aclk as the filter block; output alternates around a dc level
`timescale 1ns/1ps
`default_nettype none
module mod_source
  import dfs_pkg::*;
#(
  parameter int MOD_W = 4
) (
  // clock
  input  wire logic                    aclk,
  // dc level to encode
  input  wire logic signed [MOD_W-1:0] level,
  // sample stream
  output var logic signed [MOD_W-1:0]  mod_sample
);
  localparam logic signed [MOD_W-1:0] STEP = MOD_W'(1);
  logic phase_q = 1'b0;

  // nyquist ripple averages out exactly over any even-length window
  always_ff @(posedge aclk) begin
    phase_q    <= ~phase_q;
    mod_sample <= phase_q ? level + STEP : level - STEP;
  end
endmodule // mod_source
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for decimation_filter_select
// assumes mod_source as modulator; bench acts as host controller and axi4-lite master
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  import dfs_pkg::*;
  localparam int LIMIT = 80000;
  logic                   aclk = 1'b0;
  logic                   aresetn = 1'b0;
  logic signed [3:0]      level = 4'sh3;
  wire logic signed [3:0] mod_sample;
  logic                   start_pin = 1'b0;
  logic                   rpd_n = 1'b1;
  logic [1:0]             fsel = 2'h0;
  logic [1:0]             rsel = 2'h0;
  logic [RES_W-1:0]       result_word;
  logic                   result_valid, result_ready_n;
  logic [ADDR_W-1:0]      awaddr = '0, araddr = '0;
  logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic [31:0]            wdata = '0, rdata;
  logic [3:0]             wstrb = 4'hF;
  logic [1:0]             bresp, rresp;
  int                     n_errors = 0, check_count = 0, cyc = 0;

  always #2 aclk = ~aclk;

  mod_source #(.MOD_W(4)) src_u (.aclk(aclk), .level(level), .mod_sample(mod_sample));

  decimation_filter_select #(.MOD_W(4)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .mod_sample(mod_sample), .start_pin(start_pin),
    .reset_powerdown_pin_n(rpd_n), .filter_select(fsel), .decimation_ratio_select(rsel),
    .result_word(result_word), .result_valid(result_valid), .result_ready_n(result_ready_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // counts edges until a strobe is seen or the limit runs out
  task automatic wait_valid(input int lim, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (result_valid !== 1'b1 && n < lim);
  endtask

  task automatic reg_case();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(REG_CTRL, d, r);
    `CHK("ctrl reset", 32'h1, d);
    axi_wr(REG_RESULT, 32'hFFFFFFFF, r);
    `CHK("ro write resp", RESP_OKAY, r);
    axi_rd(REG_RESULT, d, r);
    `CHK("result untouched", 32'h0, d);
    axi_rd(5'h10, d, r);
    `CHK("unmapped read resp", RESP_SLVERR, r);
    `CHK("unmapped read data", 32'h0, d);
    axi_wr(5'h14, 32'h3, r);
    `CHK("unmapped write resp", RESP_SLVERR, r);
  endtask

  task automatic ctrl_case();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    axi_wr(REG_CTRL, 32'h0, r);
    fsel <= PATH_LL;
    rsel <= 2'h1;
    repeat (4) @(posedge aclk);
    start_pin <= 1'b1;
    wait_valid(400, n);
    `CHK("held while ctrl stopped", 400, n);
    axi_wr(REG_CTRL, 32'h1, r);
    wait_valid(500, n);
    `CHK("runs after ctrl set", 1'b1, result_valid);
    axi_rd(REG_STATUS, d, r);
    `CHK("status latched", 32'h31, d);
    axi_rd(REG_COUNT, d, r);
    `CHK("result count", 32'h1, d);
    // select change while running: latched setting holds, results continue at the old ratio
    rsel <= 2'h2;
    repeat (8) @(posedge aclk);
    axi_rd(REG_STATUS, d, r);
    `CHK("select held while running", 32'h31, d);
    start_pin <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic run_case(input logic [1:0] p, input logic [1:0] r, input int ratio, input int lo,
                          input bit use_rpd, input logic signed [3:0] lvl);
    int                     n;
    logic signed [RES_W-1:0] e;
    e = RES_W'(lvl) <<< (RES_W - 4);
    @(posedge aclk);
    level <= lvl;
    fsel  <= p;
    rsel  <= r;
    repeat (4) @(posedge aclk);
    start_pin <= 1'b1;
    wait_valid(lo + 2 * ratio + 32, n);
    `CHK("first result delay", 1'b1, n >= lo && n < lo + 2 * ratio + 32);
    `CHK("ready_n with strobe", 1'b0, result_ready_n);
    `CHK("dc result", e, result_word);
    wait_valid(ratio + 2, n);
    `CHK("result spacing", ratio, n);
    @(posedge aclk);
    `CHK("strobe width", 1'b0, result_valid);
    if (use_rpd) rpd_n <= 1'b0;
    else start_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    wait_valid(2 * ratio, n);
    `CHK("silent after stop", 2 * ratio, n);
    rpd_n     <= 1'b1;
    start_pin <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    reg_case();
    ctrl_case();
    run_case(PATH_LL, 2'h0, 32, 160, 1'b0, 4'sh3);
    run_case(PATH_LL, 2'h1, 128, 288, 1'b0, 4'sh3);
    run_case(PATH_LL, 2'h2, 512, 672, 1'b0, 4'sh3);
    run_case(PATH_LL, 2'h3, 2048, 2208, 1'b0, 4'sh3);
    run_case(2'h3, 2'h0, 32, 160, 1'b1, -4'sh3);
    run_case(PATH_WB1, 2'h0, 32, 84 * 32, 1'b0, 4'sh3);
    run_case(PATH_WB1, 2'h1, 64, 84 * 64, 1'b1, 4'sh3);
    run_case(PATH_WB1, 2'h2, 128, 84 * 128, 1'b0, -4'sh3);
    run_case(PATH_WB1, 2'h3, 256, 84 * 256, 1'b0, 4'sh3);
    run_case(PATH_WB2, 2'h0, 32, 84 * 32, 1'b0, -4'sh3);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire

// File: logic/decimation_filter_select.sv
// decimation filter with sinc5/sinc1 and two wideband FIR paths, AXI4-Lite status
// assumes modulator samples arrive every aclk; select and control pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module decimation_filter_select
  import dfs_pkg::*;
#(
  parameter int MOD_W = 4
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // modulator stream
  input  wire logic signed [MOD_W-1:0] mod_sample,
  // configuration pins
  input  wire logic                    start_pin,
  input  wire logic                    reset_powerdown_pin_n,
  input  wire logic [1:0]              filter_select,
  input  wire logic [1:0]              decimation_ratio_select,
  // results
  output logic [RES_W-1:0]             result_word,
  output logic                         result_valid,
  output logic                         result_ready_n,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0]       awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]       araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready
);
  localparam int ACC_W = MOD_W + S1_ORDER * S1_LOG2;
  localparam int S2_W  = RES_W + S2_MAXL;
  localparam int SUM_W = RES_W + COEF_W + 3;

  // pin synchronisers: a change counts once stages two and three agree
  pins_t      sy1_q, sy2_q, sy3_q, pins_q;
  wire pins_t pins_raw = {start_pin, reset_powerdown_pin_n, filter_select, decimation_ratio_select};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_q  <= PINS_RESET;
      sy2_q  <= PINS_RESET;
      sy3_q  <= PINS_RESET;
      pins_q <= PINS_RESET;
    end else begin
      sy1_q <= pins_raw;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      if (sy2_q == sy3_q) pins_q <= sy3_q;
    end
  end

  // run control
  logic       sw_run_q;
  run_state_t state_q, state_d;
  sel_t       cfg_q;
  logic       emit;
  wire logic  go  = pins_q.start & pins_q.rpd_n & sw_run_q;
  wire logic  run = (state_q != ST_IDLE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (go) state_d = ST_SETTLE;
      ST_SETTLE: if (!go) state_d = ST_IDLE; else if (emit) state_d = ST_LIVE;
      ST_LIVE:   if (!go) state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      cfg_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE) cfg_q <= pins_q.sel;
    end
  end

  wire logic       wb    = is_wideband(cfg_q);
  wire logic       wb2   = (cfg_q.path == PATH_WB2);
  wire logic [2:0] log2n = s2_log2(cfg_q);

  // cycles since start, saturating
  logic [11:0] since_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) since_q <= '0;
    else if (since_q != 12'hFFF) since_q <= since_q + 12'h001;
  end

  // sinc5 stage: five integrators at the modulator rate, five combs every 32nd sample
  logic [4:0]              ph_q;
  logic signed [ACC_W-1:0] integ_q [S1_ORDER];
  logic signed [ACC_W-1:0] dly_q [S1_ORDER];
  logic signed [ACC_W-1:0] comb_c [S1_ORDER+1];
  logic signed [RES_W-1:0] s1_q;
  logic                    s1_v_q;
  wire logic               s1_tick = run & (ph_q == S1_LAST);
  wire logic signed [ACC_W-1:0] mod_ext = {{(ACC_W-MOD_W){mod_sample[MOD_W-1]}}, mod_sample};

  // start on the last phase so decimation instants fall on multiples of 32 after start;
  // the comb output at 160 then covers a full window of live samples
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) ph_q <= S1_LAST;
    else ph_q <= ph_q + 5'h01;
  end

  assign comb_c[0] = integ_q[S1_ORDER-1];
  for (genvar k = 0; k < S1_ORDER; k++) begin : g_cic
    wire logic signed [ACC_W-1:0] in_k = (k == 0) ? mod_ext : integ_q[(k == 0) ? 0 : k-1];
    assign comb_c[k+1] = comb_c[k] - dly_q[k];
    always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
        integ_q[k] <= '0;
        dly_q[k]   <= '0;
      end else begin
        integ_q[k] <= integ_q[k] + in_k;
        if (s1_tick) dly_q[k] <= comb_c[k];
      end
    end
  end

  // top bits of the comb output give unity dc gain at full 24-bit scale
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      s1_q   <= '0;
      s1_v_q <= 1'b0;
    end else begin
      s1_v_q <= s1_tick;
      if (s1_tick) s1_q <= comb_c[S1_ORDER][ACC_W-1 -: RES_W];
    end
  end

  // second stage decimation counter, shared by all paths
  logic [5:0]             cnt2_q;
  logic signed [S2_W-1:0] acc2_q;
  wire logic [5:0] n_m1  = 6'((7'h01 << log2n) - 7'h01);
  wire logic       last2 = (cnt2_q == n_m1);
  wire logic signed [S2_W-1:0] s1_ext = {{S2_MAXL{s1_q[RES_W-1]}}, s1_q};
  wire logic signed [S2_W-1:0] ll_sum = acc2_q + s1_ext;
  wire logic signed [S2_W-1:0] ll_avg = ll_sum >>> log2n;
  wire logic signed [RES_W-1:0] ll_word = (log2n == 3'h0) ? s1_q : ll_avg[RES_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt2_q <= '0;
      acc2_q <= '0;
    end else if (s1_v_q) begin
      cnt2_q <= last2 ? 6'h00 : cnt2_q + 6'h01;
      acc2_q <= last2 ? '0 : ll_sum;
    end
  end

  // wideband FIR on the sinc5 output, decimating by ratio/32
  logic signed [RES_W-1:0] tap_q [WB_TAPS-1];
  logic signed [RES_W-1:0] win [WB_TAPS];
  logic signed [SUM_W-1:0] fir_sum;
  assign win[0] = s1_q;
  for (genvar k = 1; k < WB_TAPS; k++) begin : g_taps
    assign win[k] = tap_q[k-1];
    always_ff @(posedge aclk) begin
      if (!aresetn || !run) tap_q[k-1] <= '0;
      else if (s1_v_q) tap_q[k-1] <= win[k-1];
    end
  end

  always_comb begin
    fir_sum = '0;
    for (int k = 0; k < WB_TAPS; k++) begin
      fir_sum = fir_sum + SUM_W'(win[k]) * SUM_W'(wb2 ? WB2_COEF[k] : WB1_COEF[k]);
    end
  end
  wire logic signed [RES_W-1:0] wb_word = fir_sum[COEF_FRAC +: RES_W];

  // settling and result strobe
  logic [6:0]  wbcnt_q;
  wire logic   out_tick = run & s1_v_q & last2;
  wire logic   settled  = wb ? (wbcnt_q == WB_SETTLE) : (since_q >= LL_SETTLE[cfg_q.ratio]);
  assign emit = out_tick & settled;

  logic [RES_W-1:0] result_q;
  logic             result_valid_q, result_ready_n_q;
  logic [31:0]      count_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) wbcnt_q <= '0;
    else if (out_tick && wb && !settled) wbcnt_q <= wbcnt_q + 7'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q         <= '0;
      result_valid_q   <= 1'b0;
      result_ready_n_q <= 1'b1;
      count_q          <= '0;
    end else begin
      result_valid_q   <= emit;
      result_ready_n_q <= !emit;
      if (emit) begin
        result_q <= wb ? wb_word : ll_word;
        count_q  <= count_q + 32'h1;
      end
    end
  end

  assign result_word    = result_q;
  assign result_valid   = result_valid_q;
  assign result_ready_n = result_ready_n_q;

  // axi4-lite slave
  logic              aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
  logic              arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q, wdata_q;
  logic [3:0]        wstrb_q;
  logic [ADDR_W-1:0] awaddr_q;
  status_t           status;

  wire logic aw_hs    = awvalid & awready_q;
  wire logic w_hs     = wvalid & wready_q;
  wire logic ar_hs    = arvalid & arready_q;
  wire logic do_write = aw_have_q & w_have_q & !bvalid_q;
  wire logic aw_have_d = aw_hs | (aw_have_q & !do_write);
  wire logic w_have_d  = w_hs | (w_have_q & !do_write);
  wire logic bvalid_d  = do_write | (bvalid_q & !bready);
  wire logic rvalid_d  = ar_hs | (rvalid_q & !rready);
  wire logic wr_ctrl   = do_write & (awaddr_q[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2]) & wstrb_q[0];

  assign status = '{zero: '0, live: (state_q == ST_LIVE), running: run, sel: cfg_q};

  wire logic [ADDR_W-3:0] ar_idx = araddr[ADDR_W-1:2];
  wire logic [31:0] rd_mux =
    (ar_idx == REG_CTRL[ADDR_W-1:2])   ? {31'h0, sw_run_q} :
    (ar_idx == REG_STATUS[ADDR_W-1:2]) ? status :
    (ar_idx == REG_RESULT[ADDR_W-1:2]) ? {8'h00, result_q} :
    (ar_idx == REG_COUNT[ADDR_W-1:2])  ? count_q : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      sw_run_q  <= CTRL_RESET;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= !aw_have_d & !bvalid_d;
      wready_q  <= !w_have_d & !bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_hs) awaddr_q <= awaddr;
      if (w_hs) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) bresp_q <= reg_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      if (wr_ctrl) sw_run_q <= wdata_q[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_hs) begin
        rdata_q <= rd_mux;
        rresp_q <= reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // checks
  logic [11:0] gap_q;
  logic        seen_q;
  wire logic [11:0] ratio_m1 = (S1_RATIO << log2n) - 12'h001;
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= result_valid_q ? 12'h000 : gap_q + 12'h001;
      if (result_valid_q) seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_stage1_rate: assert property (
    s1_v_q |-> $past(ph_q) == S1_LAST) else $error("first stage output off its 32-sample phase");
  chk_bypass_word: assert property (
    emit && !wb && log2n == 3'h0 |=> result_valid && result_word == $past(s1_q))
    else $error("ratio 32 result differs from first stage output");
  chk_output_rate: assert property (
    result_valid_q && seen_q && run |-> gap_q == ratio_m1) else $error("result spacing differs from ratio");
  chk_ll_settle: assert property (
    result_valid_q && !wb |-> since_q > LL_SETTLE[cfg_q.ratio]) else $error("low-latency result before settling");
  chk_wb_settle: assert property (
    result_valid_q && wb |-> wbcnt_q == WB_SETTLE) else $error("wideband result before 84 conversions");
  chk_stop_quiet: assert property (
    state_q == ST_IDLE |=> !result_valid) else $error("result while stopped");
  chk_ready_pair: assert property (
    result_valid == !result_ready_n) else $error("ready flag disagrees with strobe");
  chk_strobe_width: assert property (
    result_valid |=> !result_valid) else $error("strobe not one cycle");
  chk_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped early");
  chk_read_answer: assert property (
    arvalid && arready |=> rvalid) else $error("read answer late");

  cov_ll_result: cover property (result_valid && !wb && log2n == 3'h6);
  cov_wb1_result: cover property (result_valid && wb && !wb2);
  cov_wb2_result: cover property (result_valid && wb2);
endmodule // decimation_filter_select
`default_nettype wire

// File: logic/dfs_pkg.sv
// constants, types and helpers for the decimation filter block
// assumes one master clock that also paces the modulator samples
// Operation
// - two-bit select picks sinc or two wideband paths
// - two-bit ratio select from pins only
// - one result per ratio modulator samples
// - one modulator sample every master clock
// - sinc5 first stage, unity gain, decimate 32
// - ratio 32 bypasses second stage; the wideband paths still run the FIR at ratio 32
// - second stage decimates 4, 16 or 64 on the low-latency path, 2, 4 or 8 on the wideband paths
// - sinc1 averages N first-stage outputs, unity gain
// - low-latency path cascades sinc5 then sinc1
// - wideband paths offer four ratios too
// - results are 24-bit, full scale plus/minus reference
// - low-latency results suppressed until settle count
// - wideband results withheld for 84 conversions
package dfs_pkg;
  localparam int RES_W    = 24;
  localparam int S1_ORDER = 5;
  localparam int S1_LOG2  = 5;
  localparam int S2_MAXL  = 6;
  localparam int ADDR_W   = 5;
  localparam int WB_TAPS  = 8;
  localparam int COEF_W   = 16;
  localparam int COEF_FRAC = 15;

  localparam logic [1:0] PATH_LL  = 2'h0;
  localparam logic [1:0] PATH_WB1 = 2'h1;
  localparam logic [1:0] PATH_WB2 = 2'h2;

  localparam logic [2:0]  LL_S2_LOG2 [4] = '{3'h0, 3'h2, 3'h4, 3'h6};
  localparam logic [2:0]  WB_S2_LOG2 [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
  localparam logic [11:0] LL_SETTLE [4]  = '{12'h0A0, 12'h120, 12'h2A0, 12'h8A0};
  localparam logic [6:0]  WB_SETTLE      = 7'h54;
  localparam logic [11:0] S1_RATIO       = 12'h020;
  localparam logic [4:0]  S1_LAST        = 5'h1F;

  // symmetric taps, each set sums to one in Q15
  localparam logic signed [COEF_W-1:0] WB1_COEF [WB_TAPS] =
    '{16'hFE00, 16'h0400, 16'h1000, 16'h2E00, 16'h2E00, 16'h1000, 16'h0400, 16'hFE00};
  localparam logic signed [COEF_W-1:0] WB2_COEF [WB_TAPS] =
    '{16'hFF00, 16'h0200, 16'h1200, 16'h2D00, 16'h2D00, 16'h1200, 16'h0200, 16'hFF00};

  localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] REG_RESULT = 5'h08;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 5'h0C;
  localparam logic              CTRL_RESET = 1'b1;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_LIVE   = 3'b100
  } run_state_t;

  typedef struct packed {
    logic [1:0] path;
    logic [1:0] ratio;
  } sel_t;

  typedef struct packed {
    logic start;
    logic rpd_n;
    sel_t sel;
  } pins_t;

  localparam pins_t PINS_RESET = 6'h00;

  typedef struct packed {
    logic [25:0] zero;
    logic        live;
    logic        running;
    sel_t        sel;
  } status_t;

  function automatic logic is_wideband(input sel_t s);
    return (s.path == PATH_WB1) || (s.path == PATH_WB2);
  endfunction

  function automatic logic [2:0] s2_log2(input sel_t s);
    if (is_wideband(s)) return WB_S2_LOG2[s.ratio];
    return LL_S2_LOG2[s.ratio];
  endfunction

  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2] <= REG_COUNT[ADDR_W-1:2];
  endfunction
endpackage
